// ===== src/mscf_clock_flag_ctrl.v
// Condition flag mux, interrupt flags and array clock generator for a microprogram sequencer
//
// Chosen here: the address map and the AHB-Lite slave port.

`include "mscf_map.vh"

module mscf_clock_flag_ctrl (
  // Clock and reset
  input  wire        mclk,
  input  wire        rst_n,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Sequencer and memory side
  input  wire        host_access_pending_n,
  input  wire [15:0] data_reg_next_value,
  input  wire        data_reg_load,
  input  wire [7:0]  ucode_word,
  input  wire        host_mem_access,
  output reg         seqFlag_ff,
  output reg  [3:0]  seqExtIrq_ff,
  output reg         arrayClk_ff,
  output reg         halt_ff,
  output reg         memEnable_n_ff,
  output reg         ucodeCe_n_ff,
  output reg         ucodeOe_n_ff,
  output reg         dataCs_n_ff,
  output reg         seqReset_n_ff,
  output reg         hostIrq_ff
);

  // ==========================================================================
  // Reset synchroniser and host_access_pending_n synchroniser
  reg        rstMeta_ff;
  reg        rstSync_ff;
  reg        pendMeta_ff;
  reg        pendSync_ff;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_ff <= 1'b0;
      rstSync_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= rstMeta_ff;
    end
  end
  wire rstN = rstSync_ff;
  always @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      pendMeta_ff <= 1'b1;
      pendSync_ff <= 1'b1;
    end else begin
      pendMeta_ff <= host_access_pending_n;
      pendSync_ff <= pendMeta_ff;
    end
  end

  // ==========================================================================
  // Register state
  reg        run_ff;
  reg        step_ff;
  reg        hostTest_ff;
  reg        hostIrqEn_ff;
  reg        microIrq_ff;
  reg        hostIrqReq_ff;
  reg  [7:0] pipe_ff;
  reg  [15:0] nextData_ff;
  reg  [1:0] clen_ff;
  reg  [3:0] cnt_ff;
  reg  [1:0] state_ff;
  reg        wrPend_ff;
  reg  [11:0] wrAddr_ff;

  localparam ST_HALT = 2'd0;
  localparam ST_LOW  = 2'd1;
  localparam ST_HIGH = 2'd2;

  // ==========================================================================
  // Bus slave: zero wait states, OKAY always, unmapped reads zero
  wire addrPhase = hsel & hready & htrans[1];
  wire doWrite   = wrPend_ff;
  wire ctrlWr    = doWrite & (wrAddr_ff == `MSCF_CTRL_OFF);
  wire cmdWr     = doWrite & (wrAddr_ff == `MSCF_CMD_OFF);
  always @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      wrPend_ff <= 1'b0;
      wrAddr_ff <= 12'h000;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wrPend_ff <= addrPhase & hwrite;
      if (addrPhase) begin
        wrAddr_ff <= haddr;
      end
      if (addrPhase & !hwrite) begin
        case (haddr)
          `MSCF_CTRL_OFF: begin
            hrdata <= {27'h0, microIrq_ff, hostIrqEn_ff, hostTest_ff, step_ff, run_ff};
          end
          `MSCF_STAT_OFF: begin
            hrdata <= {25'h0, hostIrqReq_ff, seqReset_n_ff, memEnable_n_ff,
                       arrayClk_ff, halt_ff, clen_ff};
          end
          `MSCF_DATA_OFF: begin
            hrdata <= {16'h0, nextData_ff};
          end
          `MSCF_UCODE_OFF: begin
            hrdata <= {24'h0, pipe_ff};
          end
          default: begin
            hrdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Clock generator
  wire go       = (run_ff | step_ff) & pendSync_ff;
  wire clkRise  = (state_ff == ST_LOW) & (cnt_ff == 4'd1);
  reg  [3:0] lowLen;
  always @* begin
    case (clen_ff)
      2'd0:    lowLen = `MSCF_LEN0 - 4'd1;
      2'd1:    lowLen = `MSCF_LEN1 - 4'd1;
      2'd2:    lowLen = `MSCF_LEN2 - 4'd1;
      default: lowLen = `MSCF_LEN3 - 4'd1;
    endcase
  end
  reg  [1:0] nxt_state;
  reg  [3:0] nxt_cnt;
  always @* begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      ST_HALT: begin
        if (go) begin
          nxt_state = ST_LOW;
          nxt_cnt   = lowLen;
        end
      end
      ST_LOW: begin
        if (cnt_ff == 4'd1) begin
          nxt_state = ST_HIGH;
        end else begin
          nxt_cnt = cnt_ff - 4'd1;
        end
      end
      ST_HIGH: begin
        if (go) begin
          nxt_state = ST_LOW;
          nxt_cnt   = lowLen;
        end else begin
          nxt_state = ST_HALT;
        end
      end
      default: begin
        nxt_state = ST_HALT;
      end
    endcase
  end
  // Memory window: last two low periods and the high period after the edge
  wire nxtMemOn = ((nxt_state == ST_LOW) & (nxt_cnt <= `MSCF_MEM_LEAD)) |
                  (nxt_state == ST_HIGH) |
                  ((nxt_state == ST_LOW) & (clen_ff == 2'd0));
  always @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      state_ff       <= ST_HALT;
      cnt_ff         <= 4'd0;
      halt_ff        <= 1'b1;
      arrayClk_ff    <= 1'b1;
      memEnable_n_ff <= 1'b1;
      ucodeCe_n_ff   <= 1'b1;
      ucodeOe_n_ff   <= 1'b1;
      dataCs_n_ff    <= 1'b1;
    end else begin
      state_ff       <= nxt_state;
      cnt_ff         <= nxt_cnt;
      halt_ff        <= (nxt_state == ST_HALT);
      arrayClk_ff    <= (nxt_state != ST_LOW);
      memEnable_n_ff <= ~nxtMemOn;
      ucodeCe_n_ff   <= ~(nxtMemOn | host_mem_access);
      ucodeOe_n_ff   <= ~(nxtMemOn | host_mem_access);
      dataCs_n_ff    <= ~(nxtMemOn | host_mem_access);
    end
  end

  // ==========================================================================
  // Pipeline copy and cycle length, loaded only at the array clock rise
  always @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      clen_ff <= 2'h0;
      pipe_ff <= 8'h00;
    end else if (clkRise) begin
      pipe_ff <= ucode_word;
      clen_ff <= ucode_word[`MSCF_UC_CLEN_HI:`MSCF_UC_CLEN_LO];
    end
  end

  // ==========================================================================
  // Next data register latch and condition flag
  wire [1:0] selPre = ucode_word[`MSCF_UC_SEL_HI:`MSCF_UC_SEL_LO];
  always @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      nextData_ff <= 16'h0000;
      seqFlag_ff  <= 1'b0;
    end else begin
      if ((state_ff == ST_LOW) & data_reg_load) begin
        nextData_ff <= data_reg_next_value;
      end
      case (selPre)
        2'd0:    seqFlag_ff <= ~&nextData_ff;
        2'd1:    seqFlag_ff <= |nextData_ff;
        2'd2:    seqFlag_ff <= nextData_ff[15];
        default: seqFlag_ff <= hostTest_ff;
      endcase
    end
  end

  // ==========================================================================
  // Flags and interrupts
  wire opZero  = (pipe_ff[`MSCF_UC_OP_HI:`MSCF_UC_OP_LO] == 3'd0);
  wire setReq  = clkRise & opZero & pipe_ff[`MSCF_UC_SEL_HI] & pipe_ff[`MSCF_UC_SEL_LO];
  wire clrReq  = clkRise & opZero & pipe_ff[`MSCF_UC_SEL_HI] & ~pipe_ff[`MSCF_UC_SEL_LO];
  wire clrUIrq = (state_ff == ST_LOW) & opZero &
                 ~pipe_ff[`MSCF_UC_SEL_HI] & pipe_ff[`MSCF_UC_SEL_LO];
  wire softRst = cmdWr & hwdata[`MSCF_CMD_SRST];
  wire ackReq  = cmdWr & hwdata[`MSCF_CMD_ACK];
  wire enOff   = ctrlWr & ~hwdata[`MSCF_CTRL_HIEN];
  wire uIrqOff = ctrlWr & ~hwdata[`MSCF_CTRL_HUIRQ];

  // ==========================================================================
  // Host control bits
  always @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      run_ff       <= 1'b0;
      hostTest_ff  <= 1'b0;
      hostIrqEn_ff <= 1'b0;
    end else if (ctrlWr) begin
      run_ff       <= hwdata[`MSCF_CTRL_RUN];
      hostTest_ff  <= hwdata[`MSCF_CTRL_HTEST];
      hostIrqEn_ff <= hwdata[`MSCF_CTRL_HIEN];
    end
  end

  // Step flag cleared by the cycle's rising edge; a host write wins over that clear in the same cycle
  always @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      step_ff <= 1'b0;
    end else if (ctrlWr & hwdata[`MSCF_CTRL_STEP]) begin
      step_ff <= 1'b1;
    end else if (clkRise) begin
      step_ff <= 1'b0;
    end
  end

  // Only software or microcode clears it, never the take
  always @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      microIrq_ff <= 1'b0;
    end else if (ctrlWr & hwdata[`MSCF_CTRL_HUIRQ]) begin
      microIrq_ff <= 1'b1;
    end else if (clrUIrq | softRst | uIrqOff) begin
      microIrq_ff <= 1'b0;
    end
  end

  // Set wins over every clear that lands in the same cycle
  always @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      hostIrqReq_ff <= 1'b0;
    end else if (setReq) begin
      hostIrqReq_ff <= 1'b1;
    end else if (clrReq | ackReq | softRst | enOff) begin
      hostIrqReq_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Pins towards the sequencer and the host
  always @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      seqReset_n_ff <= 1'b1;
      seqExtIrq_ff  <= 4'h0;
      hostIrq_ff    <= 1'b0;
    end else begin
      seqReset_n_ff <= ~softRst;
      seqExtIrq_ff  <= {microIrq_ff, ucode_word[`MSCF_UC_BKPT], 2'h0};
      hostIrq_ff    <= hostIrqReq_ff & hostIrqEn_ff;
    end
  end

endmodule

// ===== pkg/mscf_map.vh
// Register offsets, field positions, reset values and timing counts for the sequencer glue block
`ifndef MSCF_MAP_VH
`define MSCF_MAP_VH

// ==========================================================================
// Register byte offsets
`define MSCF_CTRL_OFF     12'h000
`define MSCF_STAT_OFF     12'h004
`define MSCF_CMD_OFF      12'h008
`define MSCF_DATA_OFF     12'h00c
`define MSCF_UCODE_OFF    12'h010

// ==========================================================================
// Control register fields
`define MSCF_CTRL_RUN     0
`define MSCF_CTRL_STEP    1
`define MSCF_CTRL_HTEST   2
`define MSCF_CTRL_HIEN    3
`define MSCF_CTRL_HUIRQ   4
`define MSCF_CTRL_RESET   32'h0000_0000

// ==========================================================================
// Command register fields (write one to act)
`define MSCF_CMD_ACK      0
`define MSCF_CMD_SRST     1

// ==========================================================================
// Microcode word fields (pre- and post-pipeline copy)
`define MSCF_UC_SEL_LO    0
`define MSCF_UC_SEL_HI    1
`define MSCF_UC_OP_LO     2
`define MSCF_UC_OP_HI     4
`define MSCF_UC_BKPT      5
`define MSCF_UC_CLEN_LO   6
`define MSCF_UC_CLEN_HI   7

// ==========================================================================
// Cycle lengths and memory window counts in oscillator periods
`define MSCF_LEN0         4'd2
`define MSCF_LEN1         4'd4
`define MSCF_LEN2         4'd8
`define MSCF_LEN3         4'd11
`define MSCF_MEM_LEAD     4'd2
`define MSCF_MEM_TRAIL    4'd1

`endif

// ===== dv/mscf_seq_model.sv
// Behavioural model of the sequencer side: microcode word source and data register
module mscf_seq_model (
  // Array clock from the block
  input  wire        arrayClk,
  // Bench programme
  input  wire [7:0]  progWord,
  input  wire        loadReq,
  input  wire [15:0] loadData,
  // Towards the block
  output wire [7:0]  ucodeWord,
  output wire        load,
  output wire [15:0] nextData
);
  timeunit 1ns; timeprecision 1ns;
  logic [15:0] heldData_ff = 16'h0000;
  // Jump-to-self microcode: the word stays live; it never enables level 7 or waits on auto clear
  assign ucodeWord = progWord;
  assign load = loadReq;
  // Register inputs show the held value when not loading, as a real data path does
  assign nextData = loadReq ? loadData : heldData_ff;
  always @(posedge arrayClk) begin
    if (loadReq) heldData_ff <= loadData;
  end
endmodule

// ===== dv/mscf_monitor.sv
// Port-level checker for the sequencer glue block
module mscf_monitor (
  // Clock and reset
  input wire        mclk, rst_n,
  // Observed ports
  input wire        arrayClk_ff, halt_ff, memEnable_n_ff, seqFlag_ff, host_mem_access,
  input wire        ucodeCe_n_ff, ucodeOe_n_ff, dataCs_n_ff, data_reg_load,
  input wire [3:0]  seqExtIrq_ff,
  input wire [7:0]  ucode_word,
  input wire [15:0] data_reg_next_value
);
  timeunit 1ns; timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // Clock generator
  chk_reset_state: assert property (
    $rose(rst_n) |-> halt_ff && arrayClk_ff && memEnable_n_ff) else $error("bad reset state");
  chk_halt_clock: assert property (halt_ff |-> arrayClk_ff)
    else $error("clock low in halt");
  chk_high_once: assert property (
    $rose(arrayClk_ff) |=> !arrayClk_ff || halt_ff) else $error("clock high too long");
  chk_low_bound: assert property ($fell(arrayClk_ff) |-> ##[1:10] arrayClk_ff)
    else $error("clock low too long");
  chk_mem_lead: assert property (
    $rose(arrayClk_ff) |-> !memEnable_n_ff && !$past(memEnable_n_ff)) else $error("late enable");
  // ==========================================================================
  // Strobes and flags
  // Strobes trail host_mem_access by one cycle, so two quiet samples are required
  chk_strobe_gate: assert property (
    !host_mem_access && !$past(host_mem_access) && memEnable_n_ff && $past(memEnable_n_ff)
    |-> ucodeCe_n_ff && ucodeOe_n_ff && dataCs_n_ff) else $error("strobe outside enable");
  chk_ext_low: assert property (seqExtIrq_ff[1:0] == 2'h0)
    else $error("low irq lines active");
  chk_flag_msb: assert property (
    (ucode_word[1:0] == 2'h2 && data_reg_load && !arrayClk_ff && $stable(data_reg_next_value))[*3]
    |=> seqFlag_ff == $past(data_reg_next_value[15])) else $error("flag not top bit");
endmodule

bind mscf_clock_flag_ctrl mscf_monitor u_mon (.mclk, .rst_n, .arrayClk_ff, .halt_ff,
  .memEnable_n_ff, .seqFlag_ff, .host_mem_access, .ucodeCe_n_ff, .ucodeOe_n_ff, .dataCs_n_ff,
  .data_reg_load, .seqExtIrq_ff, .ucode_word, .data_reg_next_value);

// ===== dv/mscf_clock_flag_ctrl_tb.sv
// Self-checking bench for the sequencer glue block
module mscf_clock_flag_ctrl_tb;
  timeunit 1ns; timeprecision 1ns;
  logic mclk = 0, rst_n = 0, hsel = 0, hwrite = 0, pa, k;
  logic host_access_pending_n = 1, host_mem_access = 0, loadReq = 0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, rd, ctrl;
  logic [7:0]  progWord = 8'h84;
  logic [15:0] loadData = 16'h0;
  wire  [31:0] hrdata;
  wire  hreadyout, hresp, seqFlag_ff, arrayClk_ff, halt_ff, memEnable_n_ff, ucodeCe_n_ff;
  wire  ucodeOe_n_ff, dataCs_n_ff, seqReset_n_ff, hostIrq_ff, data_reg_load;
  wire  [3:0]  seqExtIrq_ff;
  wire  [7:0]  ucode_word;
  wire  [15:0] data_reg_next_value;
  int miscompares = 0, n_tests = 0, i, c, p, off;
  // Flag rows {expected, test flag, select, next data}; length rows {periods, enable-off count}
  localparam logic [19:0] FR [8] = '{20'h0ffff, 20'h81234, 20'h10000, 20'h90010,
                                     20'ha8000, 20'h27fff, 20'hf0000, 20'h3ffff};
  localparam logic [7:0] LR [4] = '{8'h20, 8'h41, 8'h85, 8'hb8};

  initial forever #25 mclk = ~mclk;
  mscf_clock_flag_ctrl dut (.mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .host_access_pending_n,
    .data_reg_next_value, .data_reg_load, .ucode_word, .host_mem_access, .seqFlag_ff,
    .seqExtIrq_ff, .arrayClk_ff, .halt_ff, .memEnable_n_ff, .ucodeCe_n_ff, .ucodeOe_n_ff,
    .dataCs_n_ff, .seqReset_n_ff, .hostIrq_ff);
  mscf_seq_model u_seq (.arrayClk(arrayClk_ff), .progWord(progWord), .loadReq(loadReq),
    .loadData(loadData), .ucodeWord(ucode_word), .load(data_reg_load),
    .nextData(data_reg_next_value));

  task automatic cmp(string nm, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic ahb(logic [11:0] a, logic w, logic [31:0] d);
    @(posedge mclk); haddr <= a; hwrite <= w; hsel <= 1'b1; htrans <= 2'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wc(logic [31:0] v); ctrl = v; ahb(12'h000, 1'b1, v); endtask
  task automatic cyc(int n); repeat (n) @(posedge mclk); #1; endtask
  // One settled sample per oscillator period; k marks a rising array clock
  task automatic tick(); @(posedge mclk); #1; k = arrayClk_ff && !pa; pa = arrayClk_ff; endtask
  task automatic step(); ahb(12'h000, 1'b1, ctrl | 32'h2); pa = arrayClk_ff; c = 0;
    repeat (60) begin tick(); c += k; end endtask
  task wrap_up;
    if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin #(50 * 20000); miscompares++; wrap_up; end

  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    cyc(3); cmp("halt", 1, halt_ff); cmp("clock", 1, arrayClk_ff);
    cmp("enable", 1, memEnable_n_ff); cmp("host irq", 0, hostIrq_ff);
    ahb(12'h0f0, 1'b0, 0); cmp("unmapped", 0, rd); cmp("hresp", 0, hresp);
    loadReq <= 1'b1;
    for (i = 0; i < 8; i++) begin
      loadData <= FR[i][15:0]; progWord <= {6'h21, FR[i][17:16]};
      wc({FR[i][18], 2'h1}); cyc(40); cmp("flag", FR[i][19], seqFlag_ff);
    end
    for (i = 0; i < 4; i++) begin
      progWord <= {i[1:0], 6'h04}; pa = arrayClk_ff;
      repeat (3) do tick(); while (!k);
      p = 0; off = 0;
      do begin tick(); p++; off += memEnable_n_ff; end while (!k);
      cmp("period", LR[i][7:4], p); cmp("enable off", LR[i][3:0], off);
    end
    wc(0); cyc(30); cmp("halted", 1, halt_ff); cmp("idle enable", 1, memEnable_n_ff);
    host_access_pending_n <= 1'b0; host_mem_access <= 1'b1;
    cyc(3); cmp("host strobe", 0, ucodeCe_n_ff); host_mem_access <= 1'b0;
    wc(1); cyc(40); cmp("held off", 1, halt_ff); host_access_pending_n <= 1'b1;
    cyc(40); cmp("running", 0, halt_ff); wc(0); progWord <= 8'h04; cyc(40);
    step(); cmp("one step", 1, c);
    ahb(12'h000, 1'b0, 0); cmp("step flag", 0, rd[1]);
    wc(32'h8); progWord <= 8'h03; step(); cmp("host irq", 0, hostIrq_ff);
    step(); cmp("host irq", 1, hostIrq_ff);
    ahb(12'h008, 1'b1, 1); cyc(2); cmp("host irq", 0, hostIrq_ff);
    step(); progWord <= 8'h02; step(); step(); cmp("host irq", 0, hostIrq_ff);
    wc(32'h10); progWord <= 8'h24; step(); step();
    cmp("micro irq", 1, seqExtIrq_ff[3]); cmp("bkpt", 1, seqExtIrq_ff[2]);
    progWord <= 8'h01; step(); step(); cmp("micro irq", 0, seqExtIrq_ff[3]);
    wc(32'h10); cyc(2); cmp("micro irq", 1, seqExtIrq_ff[3]);
    ahb(12'h008, 1'b1, 32'h2); cyc(0); cmp("seq reset", 0, seqReset_n_ff);
    cyc(2); cmp("micro irq", 0, seqExtIrq_ff[3]);
    cmp("seq reset", 1, seqReset_n_ff);
    wrap_up;
  end
endmodule
